// >>> hdl/clbir_pkg.sv
// constants, field layout and carrier types of the charger limit, boost and event register slice
// assumes a 100 MHz system clock and an 8-bit register pointer from the serial port
package clbir_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_MS       = 1000;
	localparam int TICK_CYCLES   = TICK_MS * 1000000 / CLK_PERIOD_NS;

	localparam logic [7:0] ADDR_CAP   = 8'h42;
	localparam logic [7:0] ADDR_BOOST = 8'h43;
	localparam logic [7:0] ADDR_FLAGS = 8'h44;
	localparam logic [7:0] ADDR_WDCLR = 8'h46;
	localparam logic [7:0] ADDR_WDCTL = 8'h47;

	localparam logic [4:0] RST_CAP   = 5'h1F;
	localparam logic [6:0] RST_BOOST = 7'h00;
	localparam logic [1:0] RST_WDPER = 2'h1;
	localparam logic [1:0] RST_WDCLR = 2'h0;
	localparam logic       RST_WDEN  = 1'b0;

	localparam int FLAG_WARN   = 0;
	localparam int FLAG_EXP    = 4;
	localparam int FLAG_OV     = 7;
	localparam int CTL_EN      = 0;
	localparam int CTL_PER_LSB = 6;

	localparam logic [6:0] BOOST_TOP   = 7'h70;
	localparam logic [7:0] WDOG_BASE_S = 8'h10;
	localparam logic [7:0] WARN_S      = 8'h02;
	localparam logic [1:0] WD_CLR_CMD  = 2'h1;

	// serial port device address, value is arbitrary
	localparam logic [6:0] DEV_ADDR = 7'h2A;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} clbir_req_t;

	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK, ST_WDATA, ST_WACK, ST_RDATA, ST_RACK
	} clbir_i2c_state_t;

	function automatic logic [6:0] boost_sat(input logic [6:0] c);
		return (c > BOOST_TOP) ? BOOST_TOP : c;
	endfunction : boost_sat
endpackage : clbir_pkg

// >>> hdl/clbir_i2c_slave.sv
// two-wire serial register port: address byte, pointer byte, then data bytes with auto-increment
// assumes scl and sda arrive asynchronously; sda is open drain, sdaOe high pulls the line low
`timescale 1ns/1ns
`default_nettype none
module clbir_i2c_slave (
	input  wire logic              clk_sys,
	input  wire logic              nrst,
	input  wire logic              sclIn,
	input  wire logic              sdaIn,
	output logic                   sdaOut,
	output logic                   sdaOe,
	output clbir_pkg::clbir_req_t  req,
	input  wire logic [7:0]        rdData
);
	logic [1:0] sclSync_reg;
	logic [1:0] sdaSync_reg;
	logic       sclPrev_reg;
	logic       sdaPrev_reg;
	logic       scl, sda, rise, fall, start, stop;
	clbir_pkg::clbir_i2c_state_t state_reg, state_next;
	logic [7:0] shift_reg, shift_next, tx_reg, tx_next, ptr_reg, ptr_next;
	logic [2:0] cnt_reg, cnt_next;
	logic       got_reg, got_next, isRead_reg, isRead_next, mAck_reg, mAck_next, oe_reg, oe_next;
	logic       wrPulse, rdPulse, load;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			sclSync_reg <= 2'h3;
			sdaSync_reg <= 2'h3;
			sclPrev_reg <= 1'b1;
			sdaPrev_reg <= 1'b1;
		end else begin
			sclSync_reg <= {sclSync_reg[0], sclIn};
			sdaSync_reg <= {sdaSync_reg[0], sdaIn};
			sclPrev_reg <= sclSync_reg[1];
			sdaPrev_reg <= sdaSync_reg[1];
		end
	end

	assign scl   = sclSync_reg[1];
	assign sda   = sdaSync_reg[1];
	assign rise  = scl & ~sclPrev_reg;
	assign fall  = ~scl & sclPrev_reg;
	assign start = scl & sclPrev_reg & sdaPrev_reg & ~sda;
	assign stop  = scl & sclPrev_reg & ~sdaPrev_reg & sda;

	always_comb begin
		state_next  = state_reg;
		shift_next  = shift_reg;
		tx_next     = tx_reg;
		ptr_next    = ptr_reg;
		cnt_next    = cnt_reg;
		got_next    = got_reg;
		isRead_next = isRead_reg;
		mAck_next   = mAck_reg;
		oe_next     = oe_reg;
		wrPulse     = 1'b0;
		rdPulse     = 1'b0;
		load        = 1'b0;
		if (stop) begin
			state_next = clbir_pkg::ST_IDLE;
			oe_next    = 1'b0;
		end else if (start) begin
			state_next = clbir_pkg::ST_ADDR;
			cnt_next   = 3'h0;
			got_next   = 1'b0;
			oe_next    = 1'b0;
		end else if (rise) begin
			if (state_reg == clbir_pkg::ST_ADDR || state_reg == clbir_pkg::ST_PTR
					|| state_reg == clbir_pkg::ST_WDATA || state_reg == clbir_pkg::ST_RDATA) begin
				shift_next = {shift_reg[6:0], sda};
				cnt_next   = cnt_reg + 3'h1;
				got_next   = (cnt_reg == 3'h7);
			end else if (state_reg == clbir_pkg::ST_RACK) begin
				mAck_next = ~sda;
			end
		end else if (fall) begin
			unique case (state_reg)
				clbir_pkg::ST_IDLE: begin
				end
				clbir_pkg::ST_ADDR: begin
					if (got_reg) begin
						got_next = 1'b0;
						if (shift_reg[7:1] == clbir_pkg::DEV_ADDR) begin
							oe_next     = 1'b1;
							isRead_next = shift_reg[0];
							state_next  = clbir_pkg::ST_ADDR_ACK;
						end else begin
							state_next = clbir_pkg::ST_IDLE;
						end
					end
				end
				clbir_pkg::ST_ADDR_ACK: begin
					if (isRead_reg) begin
						load = 1'b1;
					end else begin
						oe_next    = 1'b0;
						state_next = clbir_pkg::ST_PTR;
					end
				end
				clbir_pkg::ST_PTR: begin
					if (got_reg) begin
						ptr_next   = shift_reg;
						got_next   = 1'b0;
						oe_next    = 1'b1;
						state_next = clbir_pkg::ST_PTR_ACK;
					end
				end
				clbir_pkg::ST_PTR_ACK, clbir_pkg::ST_WACK: begin
					oe_next    = 1'b0;
					state_next = clbir_pkg::ST_WDATA;
				end
				clbir_pkg::ST_WDATA: begin
					if (got_reg) begin
						wrPulse    = 1'b1;
						got_next   = 1'b0;
						oe_next    = 1'b1;
						ptr_next   = ptr_reg + 8'h01;
						state_next = clbir_pkg::ST_WACK;
					end
				end
				clbir_pkg::ST_RDATA: begin
					if (got_reg) begin
						got_next   = 1'b0;
						oe_next    = 1'b0;
						state_next = clbir_pkg::ST_RACK;
					end else begin
						tx_next = {tx_reg[6:0], 1'b1};
						oe_next = ~tx_reg[6];
					end
				end
				clbir_pkg::ST_RACK: begin
					if (mAck_reg) begin
						load = 1'b1;
					end else begin
						oe_next    = 1'b0;
						state_next = clbir_pkg::ST_IDLE;
					end
				end
			endcase
		end
		// byte fetch doubles as the read strobe that clears read-to-clear flags
		if (load) begin
			rdPulse    = 1'b1;
			tx_next    = rdData;
			oe_next    = ~rdData[7];
			ptr_next   = ptr_reg + 8'h01;
			cnt_next   = 3'h0;
			got_next   = 1'b0;
			state_next = clbir_pkg::ST_RDATA;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_reg  <= clbir_pkg::ST_IDLE;
			shift_reg  <= 8'h00;
			tx_reg     <= 8'h00;
			ptr_reg    <= 8'h00;
			cnt_reg    <= 3'h0;
			got_reg    <= 1'b0;
			isRead_reg <= 1'b0;
			mAck_reg   <= 1'b0;
			oe_reg     <= 1'b0;
		end else begin
			state_reg  <= state_next;
			shift_reg  <= shift_next;
			tx_reg     <= tx_next;
			ptr_reg    <= ptr_next;
			cnt_reg    <= cnt_next;
			got_reg    <= got_next;
			isRead_reg <= isRead_next;
			mAck_reg   <= mAck_next;
			oe_reg     <= oe_next;
		end
	end

	assign sdaOut = 1'b0;
	assign sdaOe  = oe_reg;
	assign req    = {wrPulse, rdPulse, ptr_reg, shift_reg};
endmodule : clbir_i2c_slave
`default_nettype wire

// >>> hdl/clbir_regs.sv
// charge current cap, boost target, watchdog and read-to-clear event flags behind the serial port
// assumes ovSenseIn is an asynchronous comparator output; flash and charge requests are on clk_sys
// Contract
// - charge current cap field, reset all ones, clamps
// - boost code linear from 3 V, 25 mV steps
// - codes above 0x70 saturate at top setting
// - effective boost target is higher of two
// - warning flag two seconds before watchdog expiry
// - expiry flag set when watchdog expires
// - bit 7 reports input above 5.9 V
// - reading event register clears its flags
// - clear pattern 01 restarts watchdog, self-returns 00
// - period code 16..128 s, applied at clear
`timescale 1ns/1ns
`default_nettype none
module clbir_regs #(
	parameter int TICK_CYCLES = clbir_pkg::TICK_CYCLES
) (
	input  wire logic       clk_sys,
	input  wire logic       nrst,
	input  wire logic       sclIn,
	input  wire logic       sdaIn,
	output logic            sdaOut,
	output logic            sdaOe,
	input  wire logic       ovSenseIn,
	input  wire logic [6:0] flashTargetCode,
	input  wire logic [4:0] chargeReqCode,
	output logic      [4:0] chargeCapCode,
	output logic      [4:0] appliedCurrentCode,
	output logic      [6:0] effBoostCode,
	output logic            wdogExpired
);
	clbir_pkg::clbir_req_t req;
	logic [7:0]  rdData;
	logic [4:0]  cap_reg, cap_next, applied_reg, applied_next;
	logic [6:0]  boost_reg, boost_next, eff_reg, eff_next, boostSat, flashSat;
	logic        warn_reg, warn_next, exp_reg, exp_next, ov_reg, ov_next;
	logic [1:0]  ovSync_reg;
	logic [1:0]  wdClr_reg, wdClr_next, wdPer_reg, wdPer_next, perAct_reg, perAct_next;
	logic        wdEn_reg, wdEn_next, expired_reg, expired_next;
	logic [31:0] tick_reg, tick_next;
	logic [7:0]  sec_reg, sec_next, period, secInc;
	logic        capWr, boostWr, clrWr, ctlWr, flagRd, tickHit, warnEvt, expEvt;

	clbir_i2c_slave u_port (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.sclIn   (sclIn),
		.sdaIn   (sdaIn),
		.sdaOut  (sdaOut),
		.sdaOe   (sdaOe),
		.req     (req),
		.rdData  (rdData)
	);

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ovSync_reg <= 2'h0;
		end else begin
			ovSync_reg <= {ovSync_reg[0], ovSenseIn};
		end
	end

	assign capWr   = req.wr && req.addr == clbir_pkg::ADDR_CAP;
	assign boostWr = req.wr && req.addr == clbir_pkg::ADDR_BOOST;
	assign ctlWr   = req.wr && req.addr == clbir_pkg::ADDR_WDCTL;
	assign clrWr   = req.wr && req.addr == clbir_pkg::ADDR_WDCLR && req.wdata[1:0] == clbir_pkg::WD_CLR_CMD;
	assign flagRd  = req.rd && req.addr == clbir_pkg::ADDR_FLAGS;
	assign period  = clbir_pkg::WDOG_BASE_S << perAct_reg;
	assign secInc  = sec_reg + 8'h01;
	assign tickHit = wdEn_reg && !expired_reg && tick_reg == 32'(TICK_CYCLES - 1);
	assign warnEvt = tickHit && secInc == period - clbir_pkg::WARN_S;
	assign expEvt  = tickHit && secInc == period;
	assign boostSat = clbir_pkg::boost_sat(boost_reg);
	assign flashSat = clbir_pkg::boost_sat(flashTargetCode);

	always_comb begin
		rdData = 8'h00;
		unique case (req.addr)
			clbir_pkg::ADDR_CAP:   rdData[4:0] = cap_reg;
			clbir_pkg::ADDR_BOOST: rdData[6:0] = boost_reg;
			clbir_pkg::ADDR_FLAGS: begin
				rdData[clbir_pkg::FLAG_WARN] = warn_reg;
				rdData[clbir_pkg::FLAG_EXP]  = exp_reg;
				rdData[clbir_pkg::FLAG_OV]   = ov_reg;
			end
			clbir_pkg::ADDR_WDCLR: rdData[1:0] = wdClr_reg;
			clbir_pkg::ADDR_WDCTL: begin
				rdData[clbir_pkg::CTL_EN]                          = wdEn_reg;
				rdData[clbir_pkg::CTL_PER_LSB+1:clbir_pkg::CTL_PER_LSB] = wdPer_reg;
			end
			default: rdData = 8'h00;
		endcase
	end

	always_comb begin
		cap_next     = capWr ? req.wdata[4:0] : cap_reg;
		boost_next   = boostWr ? req.wdata[6:0] : boost_reg;
		wdEn_next    = ctlWr ? req.wdata[clbir_pkg::CTL_EN] : wdEn_reg;
		wdPer_next   = ctlWr ? req.wdata[clbir_pkg::CTL_PER_LSB+1:clbir_pkg::CTL_PER_LSB] : wdPer_reg;
		// clear field holds a written value but drops a restart pattern one cycle later
		if (req.wr && req.addr == clbir_pkg::ADDR_WDCLR) begin
			wdClr_next = req.wdata[1:0];
		end else if (wdClr_reg == clbir_pkg::WD_CLR_CMD) begin
			wdClr_next = clbir_pkg::RST_WDCLR;
		end else begin
			wdClr_next = wdClr_reg;
		end
		// set wins over the read that clears
		warn_next    = warnEvt | (warn_reg & ~flagRd);
		exp_next     = expEvt | (exp_reg & ~flagRd);
		ov_next      = ovSync_reg[1] | (ov_reg & ~flagRd);
		perAct_next  = clrWr ? wdPer_reg : perAct_reg;
		tick_next    = tick_reg;
		sec_next     = sec_reg;
		expired_next = expired_reg;
		if (clrWr || !wdEn_reg) begin
			tick_next    = 32'h0000_0000;
			sec_next     = 8'h00;
			expired_next = 1'b0;
		end else if (tickHit) begin
			tick_next = 32'h0000_0000;
			sec_next  = secInc;
			if (expEvt) begin
				expired_next = 1'b1;
			end
		end else if (!expired_reg) begin
			tick_next = tick_reg + 32'h0000_0001;
		end
		applied_next = (chargeReqCode < cap_reg) ? chargeReqCode : cap_reg;
		eff_next     = (boostSat > flashSat) ? boostSat : flashSat;
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cap_reg     <= clbir_pkg::RST_CAP;
			boost_reg   <= clbir_pkg::RST_BOOST;
			warn_reg    <= 1'b0;
			exp_reg     <= 1'b0;
			ov_reg      <= 1'b0;
			wdClr_reg   <= clbir_pkg::RST_WDCLR;
			wdPer_reg   <= clbir_pkg::RST_WDPER;
			perAct_reg  <= clbir_pkg::RST_WDPER;
			wdEn_reg    <= clbir_pkg::RST_WDEN;
			expired_reg <= 1'b0;
			tick_reg    <= 32'h0000_0000;
			sec_reg     <= 8'h00;
			applied_reg <= 5'h00;
			eff_reg     <= 7'h00;
		end else begin
			cap_reg     <= cap_next;
			boost_reg   <= boost_next;
			warn_reg    <= warn_next;
			exp_reg     <= exp_next;
			ov_reg      <= ov_next;
			wdClr_reg   <= wdClr_next;
			wdPer_reg   <= wdPer_next;
			perAct_reg  <= perAct_next;
			wdEn_reg    <= wdEn_next;
			expired_reg <= expired_next;
			tick_reg    <= tick_next;
			sec_reg     <= sec_next;
			applied_reg <= applied_next;
			eff_reg     <= eff_next;
		end
	end

	assign chargeCapCode      = cap_reg;
	assign appliedCurrentCode = applied_reg;
	assign effBoostCode       = eff_reg;
	assign wdogExpired        = expired_reg;

	a_cap_clamp: assert property (@(posedge clk_sys) disable iff (!nrst)
		1'b1 |=> appliedCurrentCode <= $past(cap_reg))
		else $error("applied current above cap");
	a_boost_linear: assert property (@(posedge clk_sys) disable iff (!nrst)
		(boost_reg <= clbir_pkg::BOOST_TOP && flashTargetCode <= boost_reg) |=> effBoostCode == $past(boost_reg))
		else $error("linear boost code not passed through");
	a_boost_sat: assert property (@(posedge clk_sys) disable iff (!nrst)
		(boost_reg > clbir_pkg::BOOST_TOP) |=> effBoostCode >= clbir_pkg::BOOST_TOP && effBoostCode <= clbir_pkg::BOOST_TOP)
		else $error("redundant boost code not saturated");
	a_boost_max: assert property (@(posedge clk_sys) disable iff (!nrst)
		(flashTargetCode > boost_reg && flashTargetCode <= clbir_pkg::BOOST_TOP) |=> effBoostCode == $past(flashTargetCode))
		else $error("higher flash target not used");
	a_warn_set: assert property (@(posedge clk_sys) disable iff (!nrst)
		(tickHit && sec_reg == period - clbir_pkg::WARN_S - 8'h01) |=> warn_reg)
		else $error("warning flag missing two seconds before expiry");
	a_expire_set: assert property (@(posedge clk_sys) disable iff (!nrst)
		(tickHit && secInc == period) |=> exp_reg && wdogExpired)
		else $error("expiry flag missing");
	a_ov_report: assert property (@(posedge clk_sys) disable iff (!nrst)
		ovSync_reg[1] |=> ov_reg)
		else $error("over-voltage not reported");
	a_read_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
		(flagRd && !warnEvt && !expEvt && !ovSync_reg[1]) |=> !warn_reg && !exp_reg && !ov_reg)
		else $error("flags not cleared by read");
	a_clear_return: assert property (@(posedge clk_sys) disable iff (!nrst)
		(clrWr && wdEn_reg) |=> (sec_reg == 8'h00 && wdClr_reg == clbir_pkg::WD_CLR_CMD)
			##1 (wdClr_reg == clbir_pkg::RST_WDCLR))
		else $error("watchdog clear did not restart or self-return");
	a_period_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
		!clrWr |=> $stable(perAct_reg))
		else $error("period changed without clear");
	a_resv_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
		(req.addr == clbir_pkg::ADDR_CAP) |-> rdData[7:5] == 3'h0)
		else $error("reserved bits read nonzero");
	// after a read each flag holds exactly the event seen in the read cycle
	a_event_kept: assert property (@(posedge clk_sys) disable iff (!nrst)
		flagRd |=> warn_reg == $past(warnEvt)
			&& exp_reg == $past(expEvt)
			&& ov_reg == $past(ovSync_reg[1]))
		else $error("event lost on read");

	c_warn: cover property (@(posedge clk_sys) disable iff (!nrst) warnEvt);
	c_expire: cover property (@(posedge clk_sys) disable iff (!nrst) expEvt ##[1:1000] flagRd);
	c_event_kept: cover property (@(posedge clk_sys) disable iff (!nrst) flagRd && ovSync_reg[1]);
	c_read_clear: cover property (@(posedge clk_sys) disable iff (!nrst) ov_reg && flagRd);
	c_boost_sat: cover property (@(posedge clk_sys) disable iff (!nrst) boostWr && req.wdata[6:0] > clbir_pkg::BOOST_TOP);
endmodule : clbir_regs
`default_nettype wire

// >>> testbench/clbir_i2c_host.sv
// host model: two-wire serial master with start, stop and byte tasks
// assumes a pulled-up sda wire resolved outside; sdaOe high pulls it low
`timescale 1ns/1ns
`default_nettype none
module clbir_i2c_host (
	input  wire logic clk_sys,
	output logic      scl,
	output logic      sdaOe,
	input  wire logic sda
);
	initial begin
		scl = 1'b1;
		sdaOe = 1'b0;
	end
	task automatic q();
		repeat (4) @(posedge clk_sys);
	endtask : q
	task automatic start();
		q();
		sdaOe <= 1'b0;
		q();
		scl <= 1'b1;
		q();
		q();
		sdaOe <= 1'b1;
		q();
		q();
		scl <= 1'b0;
	endtask : start
	task automatic stop();
		q();
		sdaOe <= 1'b1;
		q();
		scl <= 1'b1;
		q();
		q();
		sdaOe <= 1'b0;
		q();
		q();
	endtask : stop
	task automatic put_bit(input logic b);
		q();
		sdaOe <= ~b;
		q();
		scl <= 1'b1;
		q();
		q();
		scl <= 1'b0;
	endtask : put_bit
	task automatic get_bit(output logic b);
		q();
		sdaOe <= 1'b0;
		q();
		scl <= 1'b1;
		q();
		b = sda;
		q();
		scl <= 1'b0;
	endtask : get_bit
	// ack is high when the device pulled the ninth bit low
	task automatic put_byte(input logic [7:0] d, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) put_bit(d[i]);
		get_bit(b);
		ack = ~b;
	endtask : put_byte
	task automatic get_byte(input logic ackIt, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) get_bit(d[i]);
		put_bit(~ackIt);
	endtask : get_byte
endmodule : clbir_i2c_host
`default_nettype wire

// >>> testbench/charger_limit_boost_irq_regs_tb_top.sv
// register-level tests of the charge cap, boost target and event flags
// assumes clbir_pkg compiled first and the host model beside it
`timescale 1ns/1ns
`default_nettype none
module charger_limit_boost_irq_regs_tb_top;
	localparam int TICKS = 4;
	localparam int P16   = 16 * TICKS;
	logic       clk_sys;
	logic       nrst;
	logic       scl;
	logic       hostOe;
	wire logic  sda;
	logic       sdaOut;
	logic       sdaOe;
	logic       ovSenseIn;
	logic [6:0] flashTargetCode;
	logic [4:0] chargeReqCode;
	logic [4:0] chargeCapCode;
	logic [4:0] appliedCurrentCode;
	logic [6:0] effBoostCode;
	logic       wdogExpired;
	logic [7:0] d;
	int         err_count;
	int         checks_done;
	logic [7:0] bCode [5] = '{8'h05, 8'h30, 8'h71, 8'hFF, 8'h10};
	logic [6:0] bFlash [5] = '{7'h20, 7'h20, 7'h20, 7'h20, 7'h7F};
	logic [4:0] reqs [3] = '{5'h10, 5'h03, 5'h05};

	// pull-up on the data line
	assign sda = (sdaOe ? sdaOut : 1'b1) & ~hostOe;
	always #5 clk_sys = ~clk_sys;

	clbir_regs #(.TICK_CYCLES(TICKS)) dut_u (
		.clk_sys(clk_sys), .nrst(nrst), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
		.ovSenseIn(ovSenseIn), .flashTargetCode(flashTargetCode), .chargeReqCode(chargeReqCode),
		.chargeCapCode(chargeCapCode), .appliedCurrentCode(appliedCurrentCode),
		.effBoostCode(effBoostCode), .wdogExpired(wdogExpired)
	);
	clbir_i2c_host host_u (.clk_sys(clk_sys), .scl(scl), .sdaOe(hostOe), .sda(sda));

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic settle(input int n);
		repeat (n) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask : settle
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		logic k0, k1, k2;
		host_u.start();
		host_u.put_byte({clbir_pkg::DEV_ADDR, 1'b0}, k0);
		host_u.put_byte(a, k1);
		host_u.put_byte(v, k2);
		host_u.stop();
		chk({7'h0, k0 & k1 & k2}, 8'h01);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		logic k0, k1, k2;
		host_u.start();
		host_u.put_byte({clbir_pkg::DEV_ADDR, 1'b0}, k0);
		host_u.put_byte(a, k1);
		host_u.start();
		host_u.put_byte({clbir_pkg::DEV_ADDR, 1'b1}, k2);
		host_u.get_byte(1'b0, v);
		host_u.stop();
		chk({7'h0, k0 & k1 & k2}, 8'h01);
	endtask : rd
	function automatic logic [6:0] satx(input logic [6:0] c);
		return (c > 7'h70) ? 7'h70 : c;
	endfunction : satx
	// enable with a period code, restart, then count cycles to expiry
	task automatic wd_run(input logic [1:0] code, input int lo, input int hi);
		int n;
		n = 0;
		wr(8'h47, {code, 5'h00, 1'b1});
		wr(8'h46, 8'h01);
		@(negedge clk_sys);
		chk({7'h0, wdogExpired}, 8'h00);
		while (wdogExpired !== 1'b1 && n < 300) begin
			@(negedge clk_sys);
			n++;
		end
		chk({7'h0, n >= lo && n <= hi}, 8'h01);
	endtask : wd_run
	task automatic end_sim();
		$display("checks %0d, mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_sim

	initial begin
		repeat (80000) @(posedge clk_sys);
		err_count++;
		end_sim();
	end

	initial begin
		clk_sys = 1'b0;
		nrst = 1'b0;
		ovSenseIn = 1'b0;
		flashTargetCode = 7'h00;
		chargeReqCode = 5'h00;
		err_count = 0;
		checks_done = 0;
		repeat (20) @(posedge clk_sys);
		nrst <= 1'b1;
		settle(5);
		chk({3'h0, chargeCapCode}, 8'h1F);
		rd(8'h42, d);
		chk(d, 8'h1F);
		rd(8'h43, d);
		chk(d, 8'h00);
		rd(8'h44, d);
		chk(d, 8'h00);
		rd(8'h50, d);
		chk(d, 8'h00);
		$display("reset values test done");

		wr(8'h42, 8'hE5);
		rd(8'h42, d);
		chk(d, 8'h05);
		for (int i = 0; i < 3; i++) begin
			@(posedge clk_sys);
			chargeReqCode <= reqs[i];
			settle(3);
			chk({3'h0, appliedCurrentCode}, {3'h0, (reqs[i] < 5'h05) ? reqs[i] : 5'h05});
		end
		$display("current cap test done");

		for (int i = 0; i < 5; i++) begin
			@(posedge clk_sys);
			flashTargetCode <= bFlash[i];
			wr(8'h43, bCode[i]);
			settle(3);
			d = {1'b0, (satx(bCode[i][6:0]) > satx(bFlash[i])) ? satx(bCode[i][6:0]) : satx(bFlash[i])};
			chk({1'b0, effBoostCode}, d);
			rd(8'h43, d);
			chk(d, {1'b0, bCode[i][6:0]});
		end
		$display("boost target test done");

		wd_run(2'h0, P16 - 45, P16 - 25);
		wd_run(2'h1, 2 * P16 - 45, 2 * P16 - 25);
		rd(8'h44, d);
		chk(d, 8'h11);
		rd(8'h44, d);
		chk(d, 8'h00);
		rd(8'h46, d);
		chk(d, 8'h00);
		$display("watchdog test done");

		@(posedge clk_sys);
		ovSenseIn <= 1'b1;
		repeat (4) @(posedge clk_sys);
		ovSenseIn <= 1'b0;
		wr(8'h44, 8'hFF);
		rd(8'h44, d);
		chk(d, 8'h80);
		rd(8'h44, d);
		chk(d, 8'h00);
		@(posedge clk_sys);
		ovSenseIn <= 1'b1;
		rd(8'h44, d);
		chk(d, 8'h80);
		rd(8'h44, d);
		chk(d, 8'h80);
		@(posedge clk_sys);
		ovSenseIn <= 1'b0;
		$display("over-voltage flag test done");
		end_sim();
	end
endmodule : charger_limit_boost_irq_regs_tb_top
`default_nettype wire
